// File: hdl/sts_supervisor.sv
// Purpose: undervoltage and thermal supervision of the supplies,
//          transceiver and high-side switches, with the thermal
//          fail-safe and restart sequence
// Assumes: comparator inputs are synchronous to clk; software
//          writes and clears arrive as one-cycle strobes
// Notes:   long counts are parameters so a simulation can shorten them
`timescale 1ns/100ps
`default_nettype none

// Operation
// R1: aux supply below falling threshold sets its sticky undervoltage flag
// R2: transceiver supply below threshold sets its sticky undervoltage flag
// R3: aux undervoltage flag is not set while aux ramps on or off
// R4: block overtemperature switches that block off and sets first-level flag
// R5: first-level shutdown of a block is evaluated only while it is on
// R6: aux overtemp clears its enable bits, sets its flag, stays off
// R7: transceiver overtemp blocks transmitter, fail field 01, auto re-enable
// R8: any high-side overtemp turns all off, clears controls, sets fault flags
// R9: thermal flags stay set after the condition until software clears
// R10: main supply prewarn temperature sets the sticky prewarning flag
// R11: prewarning is evaluated only while the main supply is on
// R12: second-level shutdown enters fail-safe for the cool-down time
// R13: after cool-down pass through restart into normal mode unaided
// R14: second-level flag clears only in normal mode, condition gone
// R15: second-level shutdown is evaluated only while main supply is on
// R16: main supply short must persist the filter time before flagged
// R17: cool-down time is one second counted from the core clock
// R18: clears of any flag are ignored while its condition persists
module sts_supervisor #(
	parameter int COOLDOWN_CYC  = sts_pkg::COOLDOWN_CYC,
	parameter int SHORT_CYC     = sts_pkg::SHORT_FILTER_CYC,
	parameter int RESTART_CYC   = sts_pkg::RESTART_DELAY_CYC,
	parameter int AUX_RAMP_CYC  = sts_pkg::AUX_RAMP_CYC
) (
	input  wire logic                             clk,
	input  wire logic                             rst,
	input  wire sts_pkg::sts_sense_t              sense,
	input  wire logic                             main_on,
	input  wire logic                             xcvr_active,
	input  wire logic                             aux_en_wr,
	input  wire logic [sts_pkg::AUX_EN_W-1:0]     aux_en_data,
	input  wire logic                             hs_wr_a,
	input  wire logic                             hs_wr_b,
	input  wire logic [sts_pkg::HS_REG_W-1:0]     hs_data,
	input  wire sts_pkg::sts_flags_t              flag_clr,
	input  wire logic                             xcvr_fail_clr,
	output sts_pkg::sts_flags_t                   status,
	output logic [sts_pkg::XFAIL_W-1:0]           xcvr_fail_field,
	output logic [sts_pkg::AUX_EN_W-1:0]          aux_supply_enable_bits,
	output logic                                  aux_supply_on,
	output logic [sts_pkg::HS_REG_W-1:0]          highside_control_reg_a,
	output logic [sts_pkg::HS_REG_W-1:0]          highside_control_reg_b,
	output logic [sts_pkg::HS_COUNT-1:0]          highside_switches,
	output logic                                  xcvr_tx_enable,
	output sts_pkg::sts_mode_t                    dev_mode
);

	// ==========================================================
	// helpers

	// one switch is on when its control field is non-zero
	function automatic logic sts_field_on(
		input logic [sts_pkg::HS_REG_W-1:0] r,
		input int                           slot
	);
		sts_field_on = |r[slot*sts_pkg::HS_FIELD_W +: sts_pkg::HS_FIELD_W];
	endfunction

	// ==========================================================
	// internal signals

	logic                          aux_on;
	logic                          aux_on_q;
	logic                          aux_toggle;
	logic                          aux_blank;
	logic                          aux_ramp_done;
	logic                          aux_tsd;
	logic                          xcvr_tsd;
	logic [sts_pkg::HS_COUNT-1:0]  hs_tsd;
	logic                          any_hs_tsd;
	logic                          main_pw_det;
	logic                          main_sd_det;
	logic                          short_run;
	logic                          short_done;
	logic                          cool_done;
	logic                          restart_done;
	logic                          mode_normal;
	sts_pkg::sts_mode_t            next_mode;
	sts_pkg::sts_flags_t           set_f;
	sts_pkg::sts_flags_t           cond_f;
	sts_pkg::sts_flags_t           clr_f;
	logic [sts_pkg::FLAG_N-1:0]    flag_vec;

	// ==========================================================
	// on states of the supervised blocks

	// aux supply is on whenever any enable bit is set
	assign aux_on        = |aux_supply_enable_bits;
	assign aux_supply_on = aux_on;

	// high-side switch on states from the control fields
	always_comb begin
		for (int i = 0; i < sts_pkg::HS_COUNT; i++) begin
			if (i < sts_pkg::HS_PER_REG) begin
				highside_switches[i] = sts_field_on(highside_control_reg_a, i);
			end else begin
				highside_switches[i] = sts_field_on(highside_control_reg_b,
					i - sts_pkg::HS_PER_REG);
			end
		end
	end

	// ==========================================================
	// qualified thermal and supply detections

	// first-level detections only for blocks that are on
	assign aux_tsd    = sense.aux_ot & aux_on;                 // [R5]
	assign xcvr_tsd   = sense.xcvr_ot & xcvr_active;           // [R5]
	assign hs_tsd     = sense.hs_ot & highside_switches;       // [R5]
	assign any_hs_tsd = |hs_tsd;

	// main supply thermal detections only while it is on
	assign main_pw_det = sense.main_pw & main_on;              // [R11]
	assign main_sd_det = sense.main_sd & main_on;              // [R15]

	// ==========================================================
	// aux supply enable control

	// thermal shutdown clears the enables and beats a write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aux_supply_enable_bits <= sts_pkg::AUX_EN_RST;
		end else if (aux_tsd) begin
			aux_supply_enable_bits <= sts_pkg::AUX_EN_OFF;     // [R4] [R6]
		end else if (aux_en_wr) begin
			aux_supply_enable_bits <= aux_en_data;             // re-enable only by software
		end
	end

	// ==========================================================
	// aux ramp blanking

	// previous on state to spot switch-on and switch-off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aux_on_q <= 1'b0;
		end else begin
			aux_on_q <= aux_on;
		end
	end

	assign aux_toggle = aux_on ^ aux_on_q;

	// blanking window opens on every transition
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aux_blank <= 1'b0;
		end else if (aux_toggle) begin
			aux_blank <= 1'b1;                                 // [R3]
		end else if (aux_ramp_done) begin
			aux_blank <= 1'b0;
		end
	end

	// ramp window length
	sts_timer #(
		.LIMIT (AUX_RAMP_CYC)
	) u_ramp_timer (
		.clk  (clk),
		.rst  (rst),
		.run  (aux_blank),
		.clr  (aux_toggle),
		.done (aux_ramp_done)
	);

	// ==========================================================
	// high-side switch control

	// any switch overheating while on clears both control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			highside_control_reg_a <= sts_pkg::HS_REG_RST;
		end else if (any_hs_tsd) begin
			highside_control_reg_a <= sts_pkg::HS_REG_RST;     // [R4] [R8]
		end else if (hs_wr_a) begin
			highside_control_reg_a <= hs_data;
		end
	end

	// second control register, same priority
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			highside_control_reg_b <= sts_pkg::HS_REG_RST;
		end else if (any_hs_tsd) begin
			highside_control_reg_b <= sts_pkg::HS_REG_RST;     // [R4] [R8]
		end else if (hs_wr_b) begin
			highside_control_reg_b <= hs_data;
		end
	end

	// ==========================================================
	// transceiver thermal handling

	// transmitter follows the live overtemperature, receiver stays
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xcvr_tx_enable <= 1'b0;
		end else begin
			xcvr_tx_enable <= xcvr_active & ~sense.xcvr_ot;    // [R4] [R7]
		end
	end

	// failure field is sticky, set beats clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xcvr_fail_field <= sts_pkg::XCVR_FAIL_NONE;
		end else if (xcvr_tsd) begin
			xcvr_fail_field <= sts_pkg::XCVR_FAIL_THERMAL;    // [R7] [R9]
		end else if (xcvr_fail_clr && !sense.xcvr_ot) begin
			xcvr_fail_field <= sts_pkg::XCVR_FAIL_NONE;       // [R18]
		end
	end

	// ==========================================================
	// main supply short filter

	assign short_run = sense.main_short & main_on;

	// short must persist the whole filter time
	sts_timer #(
		.LIMIT (SHORT_CYC)
	) u_short_timer (
		.clk  (clk),
		.rst  (rst),
		.run  (short_run),                                     // [R16]
		.clr  (1'b0),
		.done (short_done)
	);

	// ==========================================================
	// flag set, condition and clear terms

	always_comb begin
		set_f  = '0;
		cond_f = '0;
		clr_f  = flag_clr;
		// aux undervoltage, blanked while the regulator ramps
		set_f.aux_supply_uv_flag   = sense.aux_uv & aux_on & ~aux_blank
			& ~aux_toggle;                                     // [R1] [R3]
		cond_f.aux_supply_uv_flag  = sense.aux_uv & aux_on;
		// transceiver supply undervoltage
		set_f.xcvr_supply_uv_flag  = sense.xcvr_uv;            // [R2]
		cond_f.xcvr_supply_uv_flag = sense.xcvr_uv;
		// first-level thermal, held while any block is still hot
		set_f.first_level_thermal_flag  = aux_tsd | xcvr_tsd
			| any_hs_tsd;                                      // [R4]
		cond_f.first_level_thermal_flag = sense.aux_ot | sense.xcvr_ot
			| (|sense.hs_ot);
		// aux overtemperature status
		set_f.aux_supply_overtemp_flag  = aux_tsd;             // [R6]
		cond_f.aux_supply_overtemp_flag = sense.aux_ot;
		// all high-side fault bits together
		set_f.highside_fault_flags  = {sts_pkg::HS_COUNT{any_hs_tsd}}; // [R8]
		cond_f.highside_fault_flags = sense.hs_ot;
		// main supply prewarning
		set_f.temp_prewarn_flag  = main_pw_det;                // [R10]
		cond_f.temp_prewarn_flag = sense.main_pw;
		// second-level thermal, clear only in normal mode
		set_f.second_level_thermal_flag  = main_sd_det;        // [R14]
		cond_f.second_level_thermal_flag = sense.main_sd;
		clr_f.second_level_thermal_flag  = flag_clr.second_level_thermal_flag
			& mode_normal;                                     // [R14]
		// filtered main supply short
		set_f.main_short_flag  = short_done;                   // [R16]
		cond_f.main_short_flag = sense.main_short;
	end

	// ==========================================================
	// sticky flag bank

	// clears ignored while the condition is present
	sts_sticky #(
		.W (sts_pkg::FLAG_N)
	) u_flags (
		.clk  (clk),
		.rst  (rst),
		.set  (set_f),
		.cond (cond_f),                                        // [R18]
		.clr  (clr_f),                                         // [R9]
		.flag (flag_vec)
	);

	assign status = sts_pkg::sts_flags_t'(flag_vec);

	// ==========================================================
	// thermal fail-safe and restart sequence

	assign mode_normal = (dev_mode == sts_pkg::MODE_NORMAL);

	// cool-down counted from fail-safe entry
	sts_timer #(
		.LIMIT (COOLDOWN_CYC)
	) u_cool_timer (
		.clk  (clk),
		.rst  (rst),
		.run  (dev_mode == sts_pkg::MODE_FAIL_SAFE),           // [R17]
		.clr  (1'b0),
		.done (cool_done)
	);

	// restart hold before returning to normal
	sts_timer #(
		.LIMIT (RESTART_CYC)
	) u_restart_timer (
		.clk  (clk),
		.rst  (rst),
		.run  (dev_mode == sts_pkg::MODE_RESTART),
		.clr  (1'b0),
		.done (restart_done)
	);

	// next mode, a new shutdown wins over the restart hold but not over the cool-down end
	always_comb begin
		next_mode = dev_mode;
		case (dev_mode)
			sts_pkg::MODE_NORMAL: begin
				if (main_sd_det) begin
					next_mode = sts_pkg::MODE_FAIL_SAFE;       // [R12]
				end
			end
			sts_pkg::MODE_FAIL_SAFE: begin
				if (cool_done) begin
					next_mode = sts_pkg::MODE_RESTART;         // [R13]
				end
			end
			sts_pkg::MODE_RESTART: begin
				if (main_sd_det) begin
					next_mode = sts_pkg::MODE_FAIL_SAFE;       // [R12]
				end else if (restart_done) begin
					next_mode = sts_pkg::MODE_NORMAL;          // [R13]
				end
			end
			default: begin
				next_mode = sts_pkg::MODE_NORMAL;
			end
		endcase
	end

	// mode register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dev_mode <= sts_pkg::MODE_NORMAL;
		end else begin
			dev_mode <= next_mode;
		end
	end

endmodule
`default_nettype wire

// File: hdl/sts_pkg.sv
// Purpose: shared constants and types of the supply and thermal supervisor
// Assumes: 50 MHz core clock, typical timing figures
// Notes:   cycle counts are derived from the time figures and the clock rate
package sts_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_HZ               = 50_000_000;
	localparam int COOLDOWN_TIME_S      = 1;
	localparam int SHORT_FILTER_TIME_MS = 4;
	localparam int RESTART_DELAY_MS     = 2;
	localparam int AUX_RAMP_TIME_US     = 100;
	localparam int COOLDOWN_CYC         = COOLDOWN_TIME_S * CLK_HZ;
	localparam int SHORT_FILTER_CYC     = SHORT_FILTER_TIME_MS * (CLK_HZ / 1000);
	localparam int RESTART_DELAY_CYC    = RESTART_DELAY_MS * (CLK_HZ / 1000);
	localparam int AUX_RAMP_CYC         = AUX_RAMP_TIME_US * (CLK_HZ / 1000000);

	// ==========================================================
	// control fields and reset values
	localparam int HS_COUNT   = 4;
	localparam int HS_REG_W   = 8;
	localparam int HS_FIELD_W = 4;
	localparam int HS_PER_REG = 2;
	localparam int AUX_EN_W   = 2;
	localparam int XFAIL_W    = 2;
	localparam logic [HS_REG_W-1:0] HS_REG_RST        = 8'h00;
	localparam logic [AUX_EN_W-1:0] AUX_EN_RST        = 2'h0;
	localparam logic [AUX_EN_W-1:0] AUX_EN_OFF        = 2'h0;
	localparam logic [XFAIL_W-1:0]  XCVR_FAIL_NONE    = 2'h0;
	localparam logic [XFAIL_W-1:0]  XCVR_FAIL_THERMAL = 2'h1;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		MODE_NORMAL    = 2'b00,
		MODE_RESTART   = 2'b01,
		MODE_FAIL_SAFE = 2'b10
	} sts_mode_t;

	// comparator outputs from the analog front end
	typedef struct packed {
		logic                aux_uv;
		logic                xcvr_uv;
		logic                aux_ot;
		logic                xcvr_ot;
		logic [HS_COUNT-1:0] hs_ot;
		logic                main_pw;
		logic                main_sd;
		logic                main_short;
	} sts_sense_t;

	// sticky status flags, also used for the clear strobes
	typedef struct packed {
		logic [HS_COUNT-1:0] highside_fault_flags;
		logic                main_short_flag;
		logic                aux_supply_overtemp_flag;
		logic                temp_prewarn_flag;
		logic                second_level_thermal_flag;
		logic                first_level_thermal_flag;
		logic                xcvr_supply_uv_flag;
		logic                aux_supply_uv_flag;
	} sts_flags_t;

	localparam int FLAG_N = $bits(sts_flags_t);

endpackage

// File: hdl/sts_sticky.sv
// Purpose: bank of sticky flags with condition-qualified clear
// Assumes: set, cond and clr are synchronous to clk
// Notes:   a set in the cycle of a clear wins
`timescale 1ns/100ps
`default_nettype none
module sts_sticky #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] cond,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] flag
);

	// ==========================================================
	// flag storage: clear only takes when the condition is gone
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag <= '0;
		end else begin
			flag <= set | (flag & ~(clr & ~cond));
		end
	end

endmodule
`default_nettype wire

// File: hdl/sts_timer.sv
// Purpose: saturating run-length timer
// Assumes: LIMIT of at least one cycle
// Notes:   done stays high while run holds after LIMIT cycles
`timescale 1ns/100ps
`default_nettype none
module sts_timer #(
	parameter int LIMIT = 16
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic run,
	input  wire logic clr,
	output logic      done
);

	localparam int            CW  = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LIM = CW'(LIMIT);
	localparam logic [CW-1:0] ONE = CW'(1);

	logic [CW-1:0] count;

	// ==========================================================
	// count while run holds, restart on clr or run low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (clr || !run) begin
			count <= '0;
		end else if (count != LIM) begin
			count <= count + ONE;
		end
	end

	// expiry level
	assign done = run && (count == LIM);

endmodule
`default_nettype wire

// File: verif/sts_supervisor_props.sv
// Purpose: concurrent checks on the supervisor ports
// Assumes: shortened counts handed over by the bind
// Notes:   single clock domain, default clocking and disable
`timescale 1ns/100ps
`default_nettype none
module sts_supervisor_props #(
	parameter int COOLDOWN_CYC = 20,
	parameter int SHORT_CYC    = 8
) (
	input wire logic                         clk,
	input wire logic                         rst,
	input wire sts_pkg::sts_sense_t          sense,
	input wire logic                         main_on,
	input wire logic                         xcvr_active,
	input wire sts_pkg::sts_flags_t          flag_clr,
	input wire sts_pkg::sts_flags_t          status,
	input wire logic [sts_pkg::XFAIL_W-1:0]  xcvr_fail_field,
	input wire logic [sts_pkg::AUX_EN_W-1:0] aux_supply_enable_bits,
	input wire logic                         aux_supply_on,
	input wire logic [sts_pkg::HS_REG_W-1:0] highside_control_reg_a,
	input wire logic [sts_pkg::HS_REG_W-1:0] highside_control_reg_b,
	input wire logic [sts_pkg::HS_COUNT-1:0] highside_switches,
	input wire logic                         xcvr_tx_enable,
	input wire sts_pkg::sts_mode_t           dev_mode
);
	int fs_n;
	int sc_n;
	// cycles in fail-safe and with a live main short
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fs_n <= 0;
			sc_n <= 0;
		end else begin
			fs_n <= (dev_mode == sts_pkg::MODE_FAIL_SAFE) ? fs_n + 1 : 0;
			sc_n <= (sense.main_short && main_on) ? sc_n + 1 : 0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================
	// thermal and supply checks
	a_pw_gate: assert property (
		!main_on && !status.temp_prewarn_flag |=> !status.temp_prewarn_flag)
		else $error("prewarn set with main off");
	a_pw_keep: assert property (
		status.temp_prewarn_flag && sense.main_pw |=> status.temp_prewarn_flag)
		else $error("prewarn cleared while hot");
	a_first_sticky: assert property (
		$fell(status.first_level_thermal_flag) |-> $past(flag_clr.first_level_thermal_flag))
		else $error("first level flag dropped unasked");
	a_hs_all_off: assert property (
		|(sense.hs_ot & highside_switches) |=> highside_control_reg_a == 8'h00
		&& highside_control_reg_b == 8'h00 && &status.highside_fault_flags)
		else $error("high side not shut down");
	a_aux_shut: assert property (
		sense.aux_ot && aux_supply_on |=> aux_supply_enable_bits == sts_pkg::AUX_EN_OFF
		&& status.aux_supply_overtemp_flag && status.first_level_thermal_flag)
		else $error("aux not shut down");
	a_tx_off: assert property (
		xcvr_active && sense.xcvr_ot |=> !xcvr_tx_enable
		&& xcvr_fail_field == sts_pkg::XCVR_FAIL_THERMAL)
		else $error("transmitter not blocked");
	a_tx_back: assert property (
		xcvr_active && !sense.xcvr_ot |=> xcvr_tx_enable)
		else $error("transmitter not restored");
	a_sd_gate: assert property (
		!main_on && dev_mode == sts_pkg::MODE_NORMAL |=> dev_mode == sts_pkg::MODE_NORMAL)
		else $error("fail-safe with main off");
	a_sl_keep: assert property (
		status.second_level_thermal_flag && dev_mode != sts_pkg::MODE_NORMAL
		|=> status.second_level_thermal_flag)
		else $error("second level cleared outside normal");
	a_fs_length: assert property (
		$fell(dev_mode == sts_pkg::MODE_FAIL_SAFE) |-> fs_n == COOLDOWN_CYC + 1
		&& dev_mode == sts_pkg::MODE_RESTART)
		else $error("fail-safe length or exit wrong");
	a_short_filter: assert property (
		$rose(status.main_short_flag) |-> sc_n >= SHORT_CYC)
		else $error("short flagged before filter time");
endmodule
`default_nettype wire

// File: verif/sts_mcu_model.sv
// Purpose: controller side that clears sticky status flags
// Assumes: man is driven off the sampling edge
// Notes:   service mode echoes every set flag as a clear
`timescale 1ns/100ps
`default_nettype none
module sts_mcu_model (
	input  wire sts_pkg::sts_flags_t man,
	input  wire logic                svc,
	input  wire sts_pkg::sts_flags_t status,
	output var sts_pkg::sts_flags_t  flag_clr
);
	// read-and-clear service plus one-off clears
	assign flag_clr = man | (svc ? status : 11'h000);
endmodule
`default_nettype wire

// File: verif/sts_supervisor_tb.sv
// Purpose: self-checking bench of the supervisor
// Assumes: counts shortened through the parameters
// Notes:   inputs move on the falling edge
`timescale 1ns/100ps
`default_nettype none
module sts_supervisor_tb;
	localparam int CD = 20;
	localparam int SC = 8;
	localparam int RS = 5;
	localparam int AR = 4;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	sts_pkg::sts_sense_t sense = 11'h000;
	logic                main_on = 1'b0;
	logic                xcvr_active = 1'b0;
	logic                aux_en_wr = 1'b0;
	logic [1:0]          aux_en_data = 2'h0;
	logic                hs_wr_a = 1'b0;
	logic                hs_wr_b = 1'b0;
	logic [7:0]          hs_data = 8'h00;
	sts_pkg::sts_flags_t man = 11'h000;
	logic                svc = 1'b0;
	logic                xcvr_fail_clr = 1'b0;
	sts_pkg::sts_flags_t flag_clr;
	sts_pkg::sts_flags_t status;
	logic [1:0]          xcvr_fail_field;
	logic [1:0]          aux_supply_enable_bits;
	logic                aux_supply_on;
	logic [7:0]          highside_control_reg_a;
	logic [7:0]          highside_control_reg_b;
	logic [3:0]          highside_switches;
	logic                xcvr_tx_enable;
	sts_pkg::sts_mode_t  dev_mode;
	int                  errors = 0;
	int                  total_checks = 0;
	int                  cyc = 0;
	logic [7:0]          ra;
	logic [7:0]          rb;

	sts_supervisor #(.COOLDOWN_CYC(CD), .SHORT_CYC(SC), .RESTART_CYC(RS),
		.AUX_RAMP_CYC(AR)) sts_supervisor_inst (.clk, .rst, .sense, .main_on,
		.xcvr_active, .aux_en_wr, .aux_en_data, .hs_wr_a, .hs_wr_b, .hs_data,
		.flag_clr, .xcvr_fail_clr, .status, .xcvr_fail_field,
		.aux_supply_enable_bits, .aux_supply_on, .highside_control_reg_a,
		.highside_control_reg_b, .highside_switches, .xcvr_tx_enable, .dev_mode);
	sts_mcu_model sts_mcu_model_inst (.man, .svc, .status, .flag_clr);

	// ==========================================
	// clock and hang guard
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			end_of_test();
		end
	end

	// ==========================================
	// helpers
	function automatic logic [3:0] sw_exp(input logic [7:0] a, input logic [7:0] b);
		sw_exp = {|b[7:4], |b[3:0], |a[7:4], |a[3:0]};
	endfunction
	task automatic check(input string nm, input logic [10:0] e, input logic [10:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [2:0] w, input logic [7:0] d);
		{aux_en_wr, hs_wr_b, hs_wr_a} = w;
		aux_en_data = d[1:0];
		hs_data = d;
		step(1);
		{aux_en_wr, hs_wr_b, hs_wr_a} = 3'h0;
		step(1);
	endtask
	task automatic clr(input logic [10:0] f);
		man = f;
		step(1);
		man = 11'h000;
		step(1);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(8982));
		step(2);
		rst = 1'b0;
		check("status", 11'h000, status);
		check("mode", sts_pkg::MODE_NORMAL, dev_mode);
		for (int i = 0; i < 16; i++) begin
			ra = 8'($urandom);
			rb = 8'($urandom);
			wr(3'h1, ra);
			wr(3'h2, rb);
			check("hs_a", ra, highside_control_reg_a);
			check("hs_b", rb, highside_control_reg_b);
			check("hs_sw", sw_exp(ra, rb), highside_switches);
		end
		sense.xcvr_uv = 1'b1;
		step(1);
		clr(11'h002);
		check("xuv", 1'b1, status.xcvr_supply_uv_flag);
		sense.xcvr_uv = 1'b0;
		step(3);
		check("xuv", 1'b1, status.xcvr_supply_uv_flag);
		clr(11'h002);
		check("xuv", 1'b0, status.xcvr_supply_uv_flag);
		sense.aux_uv = 1'b1;
		wr(3'h4, 8'h01);
		check("auv", 1'b0, status.aux_supply_uv_flag);
		step(AR + 2);
		check("auv", 1'b1, status.aux_supply_uv_flag);
		sense.aux_uv = 1'b0;
		step(1);
		clr(11'h001);
		check("auv", 1'b0, status.aux_supply_uv_flag);
		sense.aux_ot = 1'b1;
		step(1);
		check("aux_en", 2'h0, aux_supply_enable_bits);
		check("aux_on", 1'b0, aux_supply_on);
		step(4);
		check("aux_en", 2'h0, aux_supply_enable_bits);
		check("first_level_thermal_flag", 11'h024, status & 11'h024);
		clr(11'h024);
		check("first_level_thermal_flag", 11'h024, status & 11'h024);
		sense.aux_ot = 1'b0;
		clr(11'h024);
		check("first_level_thermal_flag", 11'h000, status & 11'h024);
		sense.aux_ot = 1'b1;
		step(2);
		check("first_level_thermal_flag", 11'h000, status & 11'h024);
		sense.aux_ot = 1'b0;
		xcvr_active = 1'b1;
		step(1);
		check("tx", 1'b1, xcvr_tx_enable);
		sense.xcvr_ot = 1'b1;
		step(1);
		check("tx", 1'b0, xcvr_tx_enable);
		check("fail", sts_pkg::XCVR_FAIL_THERMAL, xcvr_fail_field);
		sense.xcvr_ot = 1'b0;
		step(1);
		check("tx", 1'b1, xcvr_tx_enable);
		clr(11'h004);
		xcvr_active = 1'b0;
		sense.xcvr_ot = 1'b1;
		xcvr_fail_clr = 1'b1;
		step(2);
		check("first_level_thermal_flag", 1'b0, status.first_level_thermal_flag);
		check("fail", 2'h1, xcvr_fail_field);
		check("tx", 1'b0, xcvr_tx_enable);
		sense.xcvr_ot = 1'b0;
		step(1);
		xcvr_fail_clr = 1'b0;
		check("fail", 2'h0, xcvr_fail_field);
		wr(3'h1, 8'h10);
		wr(3'h2, 8'h03);
		sense.hs_ot = 4'h4;
		step(1);
		sense.hs_ot = 4'h0;
		check("hs_a", 8'h00, highside_control_reg_a);
		check("hs_b", 8'h00, highside_control_reg_b);
		check("hsf", 4'hF, status.highside_fault_flags);
		wr(3'h1, 8'h01);
		check("hs_sw", 4'h1, highside_switches);
		sense.main_pw = 1'b1;
		step(2);
		check("tpw", 1'b0, status.temp_prewarn_flag);
		main_on = 1'b1;
		step(1);
		check("tpw", 1'b1, status.temp_prewarn_flag);
		clr(11'h010);
		check("tpw", 1'b1, status.temp_prewarn_flag);
		sense.main_pw = 1'b0;
		clr(11'h010);
		check("tpw", 1'b0, status.temp_prewarn_flag);
		sense.main_short = 1'b1;
		step(SC - 2);
		check("short", 1'b0, status.main_short_flag);
		sense.main_short = 1'b0;
		step(1);
		sense.main_short = 1'b1;
		step(SC - 2);
		check("short", 1'b0, status.main_short_flag);
		step(4);
		check("short", 1'b1, status.main_short_flag);
		sense.main_short = 1'b0;
		main_on = 1'b0;
		sense.main_sd = 1'b1;
		step(2);
		check("mode", sts_pkg::MODE_NORMAL, dev_mode);
		main_on = 1'b1;
		step(1);
		sense.main_sd = 1'b0;
		check("mode", sts_pkg::MODE_FAIL_SAFE, dev_mode);
		check("second_level_thermal_flag", 1'b1, status.second_level_thermal_flag);
		clr(11'h008);
		check("second_level_thermal_flag", 1'b1, status.second_level_thermal_flag);
		step(CD - 4);
		check("mode", sts_pkg::MODE_FAIL_SAFE, dev_mode);
		step(3);
		check("mode", sts_pkg::MODE_RESTART, dev_mode);
		sense.main_sd = 1'b1;
		step(1);
		sense.main_sd = 1'b0;
		check("mode", sts_pkg::MODE_FAIL_SAFE, dev_mode);
		step(CD + 1);
		check("mode", sts_pkg::MODE_RESTART, dev_mode);
		step(RS + 2);
		check("mode", sts_pkg::MODE_NORMAL, dev_mode);
		clr(11'h008);
		check("second_level_thermal_flag", 1'b0, status.second_level_thermal_flag);
		svc = 1'b1;
		step(2);
		svc = 1'b0;
		check("status", 11'h000, status);
		end_of_test();
	end
endmodule

bind sts_supervisor sts_supervisor_props #(
	.COOLDOWN_CYC(COOLDOWN_CYC),
	.SHORT_CYC   (SHORT_CYC)
) sts_supervisor_props_inst (.clk, .rst, .sense, .main_on, .xcvr_active,
	.flag_clr, .status, .xcvr_fail_field, .aux_supply_enable_bits, .aux_supply_on,
	.highside_control_reg_a, .highside_control_reg_b, .highside_switches,
	.xcvr_tx_enable, .dev_mode);
`default_nettype wire
